// ---- core/dsb_pkg.sv ----
// shared constants and types for the ddr burst sram port
// assumes one system clock; link clocks are levels toggled by the controller
package dsb_pkg;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int ADDR_W = 10;
  localparam int FIFO_DEPTH = 4;
  // controller pipeline stages, counted in system cycles from the command cycle
  localparam int WR_W0_STAGE = 1;
  localparam int WR_W1_STAGE = 2;
  localparam int WR_SR_LEN = 3;
  localparam int RD_W0_STAGE = 4;
  localparam int RD_W1_STAGE = 5;
  localparam int RD_SR_LEN = 6;
  localparam logic RNW_READ = 1'b1;
  localparam logic STRAP_RESET = 1'b0;

  typedef enum logic [1:0] {
    DSB_CK_PARK = 2'b00,
    DSB_CK_LOW = 2'b01,
    DSB_CK_HIGH = 2'b10
  } dsb_ck_state_t;
endpackage

// ---- core/dsb_link_if.sv ----
// link between the controller end and the sram end
// k and c are clock levels; each system cycle is one link edge slot
`timescale 1ns/1ps
interface dsb_link_if #(parameter int DATA_W = 18, parameter int LANES = 2,
  parameter int ADDR_W = 10);
  logic k;
  logic c;
  logic load_strobe_n;
  logic rnw;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [LANES-1:0] byte_lane_enable_n;
  logic [DATA_W-1:0] q;
  logic q_oe;
  modport dev (input k, c, load_strobe_n, rnw, addr, d, byte_lane_enable_n,
    output q, q_oe);
  modport ctl (output k, c, load_strobe_n, rnw, addr, d, byte_lane_enable_n,
    input q, q_oe);
endinterface

// ---- core/dsb_sram_dev.sv ----
// sram end of the ddr two-word burst port with its storage array
// assumes link clocks toggle at most once per system cycle
// Operation
// - write command, words at k and k# t+1
// - read command, words at c# t+1, c t+2
// - wide parts, second word flips address lsb
// - narrow parts, burst lsb forced 0 then 1
// - write data taken on k and k# rises
// - read data launched on c pair, strap k
// - powers up deselected with outputs released
// - each active-low lane select writes its half
// - all lanes high leaves word unchanged
// - each mask applies to its own edge
// - stopped clock holds outputs; park clocks high
// - nop finishes reads, release after c rise
// - controller puts nop between read and write
`timescale 1ns/1ps
module dsb_sram_dev #(
  parameter int ADDR_W = dsb_pkg::ADDR_W,
  parameter bit NARROW = 1'b0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // link
  dsb_link_if.dev link,
  // strap and status
  input wire logic i_single_clk_strap,
  output logic o_single_clk_mode,
  output logic o_q_driving
);
  localparam int DW = dsb_pkg::DATA_W;
  localparam int LW = DW / dsb_pkg::LANES;

  logic [DW-1:0] mem [0:(2**ADDR_W)-1];
  logic k_prev_q;
  logic oc_prev_q;
  logic strap_done_q;
  logic strap_q;
  logic cmd_wr_q;
  logic cmd_rd_q;
  logic [ADDR_W-1:0] cmd_addr_q;
  logic wr1_q;
  logic [ADDR_W-1:0] wr_addr1_q;
  logic rd0_q;
  logic rd1_q;
  logic [ADDR_W-1:0] rd_addr0_q;
  logic [ADDR_W-1:0] rd_addr1_q;
  logic [ADDR_W-1:0] rd_hold1_q;
  logic [DW-1:0] q_q;
  logic oe_q;
  logic k_rise;
  logic kn_rise;
  logic oc;
  logic oc_rise;
  logic ocn_rise;

  // first or second burst address
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] a,
    input logic second);
    logic [ADDR_W-1:0] base;
    base = a;
    if (NARROW)
    begin
      base[0] = 1'b0;
    end
    burst_addr = base ^ {{(ADDR_W-1){1'b0}}, second};
  endfunction

  // per-lane merge, active-low selects
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w, input logic [dsb_pkg::LANES-1:0] sel_n);
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < dsb_pkg::LANES; i++)
    begin
      if (!sel_n[i])
      begin
        res[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
    lane_merge = res;
  endfunction

  // edges are seen as level changes between system cycles
  assign k_rise = link.k & ~k_prev_q;
  assign kn_rise = ~link.k & k_prev_q;
  assign oc = strap_q ? link.k : link.c;
  assign oc_rise = oc & ~oc_prev_q;
  assign ocn_rise = ~oc & oc_prev_q;

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      k_prev_q <= 1'b1;
      oc_prev_q <= 1'b1;
    end
    else
    begin
      k_prev_q <= link.k;
      oc_prev_q <= oc;
    end
  end

  // strap caught once after reset release, fixed thereafter
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      strap_done_q <= 1'b0;
      strap_q <= dsb_pkg::STRAP_RESET;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      strap_q <= i_single_clk_strap;
    end
  end

  // command decode on k rise
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cmd_wr_q <= 1'b0;
      cmd_rd_q <= 1'b0;
      cmd_addr_q <= '0;
    end
    else if (k_rise)
    begin
      // rnw only counts with the strobe low
      cmd_wr_q <= ~link.load_strobe_n & (link.rnw != dsb_pkg::RNW_READ);
      cmd_rd_q <= ~link.load_strobe_n & (link.rnw == dsb_pkg::RNW_READ);
      cmd_addr_q <= link.addr;
    end
  end

  // write burst tracking: word 0 at k rise t+1, word 1 at the k# rise after
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr1_q <= 1'b0;
      wr_addr1_q <= '0;
    end
    else if (k_rise)
    begin
      wr1_q <= cmd_wr_q;
      wr_addr1_q <= burst_addr(cmd_addr_q, 1'b1);
    end
    else if (kn_rise)
    begin
      wr1_q <= 1'b0;
    end
  end

  // array writes, mask sampled with each word on its own edge
  always_ff @(posedge i_mclk)
  begin
    if (k_rise && cmd_wr_q)
    begin
      mem[burst_addr(cmd_addr_q, 1'b0)] <= lane_merge(mem[burst_addr(cmd_addr_q, 1'b0)],
        link.d, link.byte_lane_enable_n);
    end
    else if (kn_rise && wr1_q)
    begin
      mem[wr_addr1_q] <= lane_merge(mem[wr_addr1_q], link.d,
        link.byte_lane_enable_n);
    end
  end

  // read burst tracking on k rise t+1
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rd0_q <= 1'b0;
      rd_addr0_q <= '0;
      rd_addr1_q <= '0;
    end
    else if (k_rise)
    begin
      rd0_q <= cmd_rd_q;
      rd_addr0_q <= burst_addr(cmd_addr_q, 1'b0);
      rd_addr1_q <= burst_addr(cmd_addr_q, 1'b1);
    end
  end

  // output launch on c pair, or k pair when strapped; with no clock edges everything holds
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      q_q <= '0;
      oe_q <= 1'b0;
      rd1_q <= 1'b0;
      rd_hold1_q <= '0;
    end
    else if (ocn_rise && rd0_q)
    begin
      q_q <= mem[rd_addr0_q];
      oe_q <= 1'b1;
      rd1_q <= 1'b1;
      rd_hold1_q <= rd_addr1_q;
    end
    else if (oc_rise)
    begin
      if (rd1_q)
      begin
        q_q <= mem[rd_hold1_q];
        rd1_q <= 1'b0;
      end
      else
      begin
        // pending read has ended: release on this c rise
        oe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_single_clk_mode <= dsb_pkg::STRAP_RESET;
      o_q_driving <= 1'b0;
    end
    else
    begin
      o_single_clk_mode <= strap_q;
      o_q_driving <= oe_q;
    end
  end

  assign link.q = q_q;
  assign link.q_oe = oe_q;
endmodule

// ---- core/dsb_sram_ctl.sv ----
// controller end of the ddr two-word burst port plus its request fifo
// assumes the sram end answers with the fixed pipeline in dsb_pkg
`timescale 1ns/1ps
module dsb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = dsb_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [0:DEPTH-1];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;
  logic [PW:0] cnt_d;

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = buf_q[rp_q];
  assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

  // full and empty kept in flops so ready needs no logic behind it
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else
    begin
      wp_q <= push ? PW'((wp_q + 1'b1) % DEPTH) : wp_q;
      rp_q <= pop ? PW'((rp_q + 1'b1) % DEPTH) : rp_q;
      cnt_q <= cnt_d;
      o_in_ready <= (cnt_d != (PW+1)'(DEPTH));
      o_out_valid <= (cnt_d != '0);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      buf_q[wp_q] <= i_in_data;
    end
  end
endmodule

module dsb_sram_ctl #(
  parameter int ADDR_W = dsb_pkg::ADDR_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // link
  dsb_link_if.ctl link,
  // requests
  input wire logic i_clk_run,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_rnw,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [2*dsb_pkg::DATA_W-1:0] i_req_wdata,
  input wire logic [2*dsb_pkg::LANES-1:0] i_req_lane_n,
  // read answers
  output logic o_rd_valid,
  output logic [2*dsb_pkg::DATA_W-1:0] o_rd_data
);
  localparam int DW = dsb_pkg::DATA_W;
  localparam int NL = dsb_pkg::LANES;
  localparam int FW = 1 + ADDR_W + 2*DW + 2*NL;

  dsb_pkg::dsb_ck_state_t ck_q;
  dsb_pkg::dsb_ck_state_t ck_d;
  logic [FW-1:0] head;
  logic head_valid;
  logic fire;
  logic last_rd_q;
  logic [dsb_pkg::WR_SR_LEN-1:0] wr_sr_q;
  logic [dsb_pkg::RD_SR_LEN-1:0] rd_sr_q;
  logic [DW-1:0] w1_q;
  logic [NL-1:0] m1_q;
  logic [DW-1:0] w0_q;
  logic [NL-1:0] m0_q;
  logic [DW-1:0] w1_hold_q;
  logic [NL-1:0] m1_hold_q;
  logic busy;
  logic k_q;
  logic c_q;
  logic ld_n_q;
  logic rnw_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DW-1:0] d_q;
  logic [NL-1:0] lane_q;

  dsb_fifo #(.WIDTH(FW), .DEPTH(dsb_pkg::FIFO_DEPTH)) u_req_fifo (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_in_valid(i_req_valid),
    .o_in_ready(o_req_ready),
    .i_in_data({i_req_rnw, i_req_addr, i_req_wdata, i_req_lane_n}),
    .o_out_valid(head_valid),
    .i_out_ready(fire),
    .o_out_data(head)
  );

  assign busy = (|wr_sr_q) | (|rd_sr_q);
  // a write straight after a read waits one nop slot
  assign fire = (ck_q == dsb_pkg::DSB_CK_LOW) & head_valid
    & ~(~head[FW-1] & last_rd_q);

  always_comb
  begin
    case (ck_q)
      dsb_pkg::DSB_CK_PARK: ck_d = i_clk_run ? dsb_pkg::DSB_CK_LOW : dsb_pkg::DSB_CK_PARK;
      dsb_pkg::DSB_CK_LOW: ck_d = dsb_pkg::DSB_CK_HIGH;
      // stop only between bursts, clocks parked high
      dsb_pkg::DSB_CK_HIGH: ck_d = (!i_clk_run && !busy) ? dsb_pkg::DSB_CK_PARK
        : dsb_pkg::DSB_CK_LOW;
      default: ck_d = dsb_pkg::DSB_CK_PARK;
    endcase
  end

  // c mirrors k, so both pairs carry one timing
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ck_q <= dsb_pkg::DSB_CK_PARK;
      k_q <= 1'b1;
      c_q <= 1'b1;
    end
    else
    begin
      ck_q <= ck_d;
      k_q <= (ck_d != dsb_pkg::DSB_CK_LOW);
      c_q <= (ck_d != dsb_pkg::DSB_CK_LOW);
    end
  end

  // command issue, visible with the k rise
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ld_n_q <= 1'b1;
      rnw_q <= dsb_pkg::RNW_READ;
      addr_q <= '0;
      last_rd_q <= 1'b0;
    end
    else if (ck_q == dsb_pkg::DSB_CK_LOW)
    begin
      ld_n_q <= ~fire;
      rnw_q <= head[FW-1];
      addr_q <= head[FW-2 -: ADDR_W];
      last_rd_q <= fire & head[FW-1];
    end
    else
    begin
      ld_n_q <= 1'b1;
    end
  end

  // write data: word 0 for k rise t+1, word 1 for k# rise t+1
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_sr_q <= '0;
      w0_q <= '0;
      m0_q <= '1;
      w1_q <= '0;
      m1_q <= '1;
      w1_hold_q <= '0;
      m1_hold_q <= '1;
      d_q <= '0;
      lane_q <= '1;
    end
    else
    begin
      wr_sr_q <= {wr_sr_q[dsb_pkg::WR_SR_LEN-2:0], fire & ~head[FW-1]};
      if (fire)
      begin
        w0_q <= head[2*NL+2*DW-1 -: DW];
        w1_q <= head[2*NL+DW-1 -: DW];
        m0_q <= head[2*NL-1 -: NL];
        m1_q <= head[NL-1:0];
      end
      if (wr_sr_q[dsb_pkg::WR_W0_STAGE])
      begin
        d_q <= w0_q;
        lane_q <= m0_q;
        // a write issued in this slot reloads w1_q, so word 1 moves on here
        w1_hold_q <= w1_q;
        m1_hold_q <= m1_q;
      end
      else if (wr_sr_q[dsb_pkg::WR_W1_STAGE])
      begin
        d_q <= w1_hold_q;
        lane_q <= m1_hold_q;
      end
      else
      begin
        lane_q <= '1;
      end
    end
  end

  // read capture at the fixed c# t+1 and c t+2 launch points
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rd_sr_q <= '0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end
    else
    begin
      rd_sr_q <= {rd_sr_q[dsb_pkg::RD_SR_LEN-2:0], fire & head[FW-1]};
      o_rd_valid <= rd_sr_q[dsb_pkg::RD_W1_STAGE];
      if (rd_sr_q[dsb_pkg::RD_W0_STAGE])
      begin
        o_rd_data[2*DW-1 -: DW] <= link.q;
      end
      if (rd_sr_q[dsb_pkg::RD_W1_STAGE])
      begin
        o_rd_data[DW-1:0] <= link.q;
      end
    end
  end

  assign link.k = k_q;
  assign link.c = c_q;
  assign link.load_strobe_n = ld_n_q;
  assign link.rnw = rnw_q;
  assign link.addr = addr_q;
  assign link.d = d_q;
  assign link.byte_lane_enable_n = lane_q;
endmodule

// ---- dv/dsb_link_monitor.sv ----
// link checker for the ddr burst port, watching the wide pair
// assumes link signals change once per system clock
`timescale 1ns/1ps
module dsb_link_monitor #(
  parameter int DATA_W = 18,
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // link signals
  input wire logic k,
  input wire logic c,
  input wire logic load_strobe_n,
  input wire logic rnw,
  input wire logic [LANES-1:0] byte_lane_enable_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic q_oe
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  logic rd_cmd;
  logic wr_cmd;
  assign rd_cmd = !load_strobe_n && rnw;
  assign wr_cmd = !load_strobe_n && !rnw;

  property p_cmd_on_k_rise;
    !load_strobe_n |-> k && !$past(k);
  endproperty
  a_cmd_on_k_rise: assert property (p_cmd_on_k_rise)
    else $error("command outside a k rise");
  property p_c_follows_k;
    c == k;
  endproperty
  a_c_follows_k: assert property (p_c_follows_k)
    else $error("output clock apart from input clock");
  property p_rd_drive;
    rd_cmd |-> ##4 q_oe [*3];
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read burst not driven in time");
  property p_oe_cause;
    $rose(q_oe) |-> $past(rd_cmd, 4);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data driven without a read");
  property p_release;
    rd_cmd ##1 !rd_cmd [*6] |=> !q_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("data not released after read");
  property p_rd_wr_gap;
    rd_cmd |=> !wr_cmd [*3];
  endproperty
  a_rd_wr_gap: assert property (p_rd_wr_gap)
    else $error("write too close after read");
  property p_lanes_in_slots;
    (byte_lane_enable_n != '1) |-> $past(wr_cmd, 2) || $past(wr_cmd, 3);
  endproperty
  a_lanes_in_slots: assert property (p_lanes_in_slots)
    else $error("lane select outside a data slot");
  property p_stopped_hold;
    k && $past(k) && $past(k, 2) |-> $stable(q) && $stable(q_oe);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold)
    else $error("outputs moved with clock stopped");

  c_read: cover property (rd_cmd);
  c_write: cover property (wr_cmd);
  c_partial: cover property (byte_lane_enable_n != '1 && byte_lane_enable_n != '0);
  c_stopped: cover property (k && $past(k) && $past(k, 2));
endmodule

// ---- dv/testbench.sv ----
// self-checking bench: wide and narrow pairs fed the same requests
// assumes the fixed pipeline and in-order answers of the controller end
`timescale 1ns/1ps
module testbench;
  logic i_mclk;
  logic i_reset;
  logic clk_run;
  logic req_valid;
  logic req_rnw;
  logic [dsb_pkg::ADDR_W-1:0] req_addr;
  logic [35:0] req_wdata;
  logic [3:0] req_lane_n;
  logic rdy_w, rdy_n, rdv_w, rdv_n, mode_w, drv_w, mode_n, drv_n;
  logic [35:0] rdd_w, rdd_n;
  // own copies of storage, one per burst addressing flavour
  logic [17:0] mem_w [1024];
  logic [17:0] mem_n [1024];
  logic [35:0] exp_w[$];
  logic [35:0] exp_n[$];
  int n_fail = 0;
  int cmp_count = 0;
  dsb_link_if link_w();
  dsb_link_if link_n();

  dsb_sram_ctl dsb_sram_ctl_i (.i_mclk(i_mclk), .i_reset(i_reset), .link(link_w.ctl),
    .i_clk_run(clk_run), .i_req_valid(req_valid), .o_req_ready(rdy_w), .i_req_rnw(req_rnw),
    .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_req_lane_n(req_lane_n),
    .o_rd_valid(rdv_w), .o_rd_data(rdd_w));
  dsb_sram_dev dsb_sram_dev_i (.i_mclk(i_mclk), .i_reset(i_reset), .link(link_w.dev),
    .i_single_clk_strap(1'b0), .o_single_clk_mode(mode_w), .o_q_driving(drv_w));
  dsb_sram_ctl dsb_sram_ctl_i2 (.i_mclk(i_mclk), .i_reset(i_reset), .link(link_n.ctl),
    .i_clk_run(clk_run), .i_req_valid(req_valid), .o_req_ready(rdy_n), .i_req_rnw(req_rnw),
    .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_req_lane_n(req_lane_n),
    .o_rd_valid(rdv_n), .o_rd_data(rdd_n));
  dsb_sram_dev #(.NARROW(1'b1)) dsb_sram_dev_i2 (.i_mclk(i_mclk), .i_reset(i_reset),
    .link(link_n.dev), .i_single_clk_strap(1'b1), .o_single_clk_mode(mode_n),
    .o_q_driving(drv_n));
  dsb_link_monitor dsb_link_monitor_i (.i_mclk(i_mclk), .i_reset(i_reset), .k(link_w.k),
    .c(link_w.c), .load_strobe_n(link_w.load_strobe_n), .rnw(link_w.rnw),
    .byte_lane_enable_n(link_w.byte_lane_enable_n), .q(link_w.q), .q_oe(link_w.q_oe));

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] nw,
    input logic [1:0] m);
    merge = o;
    if (!m[0]) merge[8:0] = nw[8:0];
    if (!m[1]) merge[17:9] = nw[17:9];
  endfunction

  // entered just after an edge; leaves valid high so back-to-back pushes stay legal
  task automatic push(input logic rnw, input logic [9:0] a, input logic [35:0] wd,
    input logic [3:0] ln);
    logic [9:0] a1;
    logic [9:0] b0;
    int n;
    a1 = a ^ 10'h001;
    b0 = {a[9:1], 1'b0};
    n = 0;
    if (rnw)
    begin
      exp_w.push_back({mem_w[a], mem_w[a1]});
      exp_n.push_back({mem_n[b0], mem_n[b0 | 10'h001]});
    end
    else
    begin
      mem_w[a] = merge(mem_w[a], wd[35:18], ln[3:2]);
      mem_w[a1] = merge(mem_w[a1], wd[17:0], ln[1:0]);
      mem_n[b0] = merge(mem_n[b0], wd[35:18], ln[3:2]);
      mem_n[b0 | 10'h001] = merge(mem_n[b0 | 10'h001], wd[17:0], ln[1:0]);
    end
    req_rnw = rnw;
    req_addr = a;
    req_wdata = wd;
    req_lane_n = ln;
    req_valid = 1'b1;
    while (!(rdy_w === 1'b1 && rdy_n === 1'b1) && n < 200)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    check("request taken", 36'(n == 200), '0);
    @(posedge i_mclk);
    #1;
  endtask

  task automatic drain();
    int n;
    req_valid = 1'b0;
    n = 0;
    while ((exp_w.size() != 0 || exp_n.size() != 0) && n < 400)
    begin
      @(posedge i_mclk);
      n++;
    end
    check("pending reads", 36'(exp_w.size() + exp_n.size()), '0);
    repeat (8) @(posedge i_mclk);
    #1;
  endtask

  // mid-cycle sampling keeps clear of the edge that launches the answer
  always @(negedge i_mclk)
  begin
    if (rdv_w === 1'b1 && exp_w.size() == 0)
      check("wide read count", 36'h1, '0);
    else if (rdv_w === 1'b1)
      check("wide read", rdd_w, exp_w.pop_front());
    if (rdv_n === 1'b1 && exp_n.size() == 0)
      check("narrow read count", 36'h1, '0);
    else if (rdv_n === 1'b1)
      check("narrow read", rdd_n, exp_n.pop_front());
  end

  initial
  begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    i_reset = 1'b1;
    clk_run = 1'b0;
    req_valid = 1'b0;
    req_rnw = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_lane_n = 4'hf;
    repeat (8) @(posedge i_mclk);
    #1;
    i_reset = 1'b0;
    // clocks parked: four writes fill the fifo, nothing reaches the link
    for (int i = 0; i < 4; i++)
      push(1'b0, 10'(i), {18'(18'h2a000 + i), 18'(18'h15000 + i)}, 4'h0);
    check("ready when full", 36'(rdy_w), '0);
    check("parked k", 36'(link_w.k), 36'h1);
    check("released q", 36'(link_w.q_oe), '0);
    check("strap mode", 36'(mode_w), '0);
    check("narrow strap mode", 36'(mode_n), 36'h1);
    check("narrow released q", 36'(drv_n), '0);
    req_valid = 1'b0;
    clk_run = 1'b1;
    @(posedge i_mclk);
    #1;
    for (int i = 0; i < 4; i++)
      push(1'b1, 10'(i), '0, 4'hf);
    drain();
    // every lane code on each edge, read right before the next write
    push(1'b0, 10'h004, {18'h3ffff, 18'h00000}, 4'h0);
    for (int m = 0; m < 4; m++)
    begin
      push(1'b0, 10'h005, {18'(18'h0c0f0 + m), 18'(18'h30f03 + m)}, {2'(m), 2'(3 - m)});
      push(1'b1, 10'h005, '0, 4'hf);
      push(1'b1, 10'h004, '0, 4'hf);
    end
    drain();
    // stop with the link idle after the drain, then restart with one more read
    clk_run = 1'b0;
    repeat (6) @(posedge i_mclk);
    #1;
    check("stopped q_oe", 36'(link_w.q_oe), '0);
    check("stopped driving", 36'(drv_w), '0);
    check("stopped k", 36'(link_w.k), 36'h1);
    check("stopped narrow driving", 36'(drv_n), '0);
    clk_run = 1'b1;
    push(1'b1, 10'h005, '0, 4'hf);
    drain();
    report_and_stop();
  end
endmodule
